// >>> include/stl1_pkg.sv
// Package of the layer-1 line control and status register bank.
// Assumes an 8-bit register port and line-side strobes synchronous to clk.
package stl1_pkg;

	// Register offsets on the host port
	localparam logic [7:0] ADDR_CONF0 = 8'h30;
	localparam logic [7:0] ADDR_STA   = 8'h31;
	localparam logic [7:0] ADDR_CMD   = 8'h32;
	localparam logic [7:0] ADDR_MAINT_CHANNEL_RECEIVE_1 = 8'h33;
	localparam logic [7:0] ADDR_MAINT_CHANNEL_TRANSMIT_1 = 8'h34;
	localparam logic [7:0] ADDR_MAINT_CHANNEL_RECEIVE_2 = 8'h35;
	localparam logic [7:0] ADDR_MAINT_CHANNEL_TRANSMIT_2 = 8'h36;
	localparam logic [7:0] ADDR_MAINT_CHANNEL_RECEIVE_3 = 8'h37;
	localparam logic [7:0] ADDR_MAINT_CHANNEL_TRANSMIT_3 = 8'h38;
	localparam logic [7:0] ADDR_ISTAT = 8'h39;
	localparam logic [7:0] ADDR_MODE  = 8'h3a;
	localparam logic [7:0] ADDR_MASK  = 8'h3b;

	// Values after reset
	localparam logic [7:0] CONF0_RST = 8'h01;
	localparam logic [7:0] STA_RST   = 8'h00;
	localparam logic [7:0] CMD_RST   = 8'h08;
	localparam logic [7:0] MAINT_CHANNEL_TRANSMIT_1_RST = 8'h4f;
	localparam logic [7:0] SQXR_RST  = 8'h00;
	localparam logic [7:0] SQRR_RST  = 8'h00;
	localparam logic [7:0] MASK_RST  = 8'hff;
	localparam logic [3:0] MODE_RST  = 4'h0;

	// Field positions and writable bits
	localparam int         CONF0_SOFTWARE_LAYER1_SELECT  = 3;
	localparam int         CONF0_EXTERNAL_LOOP_SELECT  = 1;
	localparam logic [7:0] CONF0_WMASK = 8'heb;
	localparam int         CMD_TRANSMIT_SIGNAL_FIELD    = 5;
	localparam int         CMD_DCHAN_PRIORITY_CLASS   = 4;
	localparam int         CMD_TRANSMIT_DATA_DISABLE   = 3;
	localparam int         CMD_PD      = 2;
	localparam int         CMD_LPA     = 0;
	localparam logic [7:0] CMD_WMASK   = 8'hfd;
	localparam logic [7:0] DCHAN_PRIORITY_CLASS_MASK  = 8'h10;
	localparam int         STA_RECEIVED_SIGNAL_FIELD    = 6;
	localparam int         STA_SLIP    = 4;
	localparam int         STA_ICV     = 3;
	localparam int         STA_FRAME_LOCK_FLAG    = 2;
	localparam int         STA_LD      = 0;
	localparam int         SQ_MULTIFRAME_LOCK_FLAG     = 7;
	localparam int         SQ_MULTIFRAME_ENABLE     = 6;
	localparam int         IST_LD      = 3;
	localparam int         IST_RIC     = 2;
	localparam int         IST_SQC     = 1;
	localparam int         IST_SQW     = 0;
	localparam int         MODE_DCH    = 3;

	// Operating modes
	localparam logic [2:0] OPM_TE     = 3'b000;
	localparam logic [2:0] OPM_LTT    = 3'b001;
	localparam logic [2:0] OPM_NT     = 3'b010;
	localparam logic [2:0] OPM_LTS    = 3'b011;
	localparam logic [2:0] OPM_INT_NT = 3'b110;
	localparam logic [2:0] OPM_INT_LT = 3'b111;

	// Transmit and receive signal codes
	localparam logic [2:0] TRANSMIT_SIGNAL_FIELD_IDLE   = 3'b000;
	localparam logic [2:0] TRANSMIT_SIGNAL_FIELD_LOW    = 3'b010;
	localparam logic [2:0] TRANSMIT_SIGNAL_FIELD_HIGH   = 3'b011;
	localparam logic [2:0] TRANSMIT_SIGNAL_FIELD_CONT   = 3'b100;
	localparam logic [2:0] TRANSMIT_SIGNAL_FIELD_SINGLE = 3'b101;
	localparam logic [1:0] RECEIVED_SIGNAL_FIELD_IDLE   = 2'b00;
	localparam logic [1:0] RECEIVED_SIGNAL_FIELD_OTHER  = 2'b01;
	localparam logic [1:0] RECEIVED_SIGNAL_FIELD_INFO2  = 2'b10;
	localparam logic [1:0] RECEIVED_SIGNAL_FIELD_HIGH   = 2'b11;

	// Multiframe layout: five subchannels, four bits each
	localparam logic [2:0] SUB_LAST = 3'd5;
	localparam logic [1:0] BIT_LAST = 2'd3;
	localparam logic [2:0] SUB_FIRST = 3'd1;

	typedef enum logic {ST_STRAP, ST_RUN} stl1_state_t;

	function automatic logic isTeSide(input logic [2:0] m);
		return (m == OPM_TE) || (m == OPM_LTT);
	endfunction

	function automatic logic isIntNt(input logic [2:0] m);
		return (m == OPM_INT_NT) || (m == OPM_INT_LT);
	endfunction

	function automatic logic isNtSide(input logic [2:0] m);
		return (m == OPM_NT) || (m == OPM_LTS) || isIntNt(m);
	endfunction

endpackage

// >>> rtl/stl1_mf_counter.sv
// Multiframe position tracker: frame to subchannel and bit slot.
// Assumes frameStrobe pulses once per line frame and mfStart marks frame 1.
`timescale 1ns/10ps
module stl1_mf_counter
	import stl1_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       frameStrobe,
	input  wire logic       mfStart,
	output logic [2:0]      curSub,
	output logic [1:0]      curBit,
	output logic            curLast,
	output logic [2:0]      nextSub,
	output logic [1:0]      nextBit
);

	logic [2:0] sub_ff;
	logic [1:0] bit_ff;
	logic [2:0] nxt_sub;
	logic [1:0] nxt_bit;

	// Multiframe alignment overrides the running count
	assign curSub  = mfStart ? SUB_FIRST : sub_ff;
	assign curBit  = mfStart ? 2'd0 : bit_ff;
	assign curLast = (curSub == SUB_LAST) && (curBit == BIT_LAST);
	assign nxt_sub = (curSub == SUB_LAST) ? SUB_FIRST : curSub + 3'd1;
	assign nxt_bit = (curSub == SUB_LAST) ? curBit + 2'd1 : curBit;
	assign nextSub = sub_ff;
	assign nextBit = bit_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sub_ff <= SUB_FIRST;
			bit_ff <= 2'd0;
		end else if (frameStrobe) begin
			sub_ff <= nxt_sub;
			bit_ff <= nxt_bit;
		end
	end

endmodule

// >>> rtl/stl1_line_regs.sv
// Layer-1 line control and status registers with maintenance channel.
// Assumes synchronous line-side inputs and a one-cycle-strobe host port.
// Operation
// - Status register matters to software only when software layer 1 selected.
// - Received signal field: 00 idle, 01 other, 10 TE second, 11 top.
// - Status bits show frame lock, slip and code violation as ones.
// - Line activity bit is zero without receive signal, one with.
// - Command writes only with software layer 1; priority also in smart NT; output and readback show that bit only with software layer 1.
// - Transmit field 000, 010, 011 select idle, low and top signals.
// - Codes 100 and 101 send continuous and single test pulses.
// - Priority bit zero selects class 1, one selects class 2.
// - TE with data disable sending top signal forces B and D to ones.
// - Power-down bit one powers down, zero returns to operation.
// - Loop bit closes analog loop, internal or external per config bit.
// - Multiframe lock bit reads one when locked to auxiliary framing.
// - Multiframe enable switches structure; mirrored in first receive register.
// - Subchannel 1 uses frames 1, 6, 11, 16 both directions.
// - Subchannels 2 and 3 use frames 2..17 and 3..18, TE receive.
// - Subchannels 4, 5 in frames 4..19, 5..20; NT send, TE receive.
// - Line activity interrupt bit stays one while signal present.
// - Signal change interrupt on field or violation change; status read clears.
// - Received maintenance change raises interrupt; matching register read clears.
// - Writable interrupt each multiframe; maintenance transmit write clears.
// - Mask bit zero enables, one suppresses; mask resets to all ones.
// - Inhibit bit XOR pin inverts echo bits in NT-side modes.
// - Mode field decodes six modes; two low bits loaded from straps.
// - Software layer 1 select disables internal activation state machine.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module stl1_line_regs
	import stl1_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrStb,
	input  wire logic       regRdStb,
	output logic [7:0]      regRdData,
	input  wire logic       detInfo0,
	input  wire logic       detInfo2,
	input  wire logic       detInfoHigh,
	input  wire logic       rxCodeViol,
	input  wire logic       rxFrameLock,
	input  wire logic       rxSlip,
	input  wire logic       rxLevel,
	input  wire logic       rxMfLock,
	input  wire logic       frameStrobe,
	input  wire logic       mfStart,
	input  wire logic       rxAuxBit,
	input  wire logic [2:0] smXmitCode,
	input  wire logic       smDprio,
	input  wire logic       smTddis,
	input  wire logic       smPowerDown,
	input  wire logic       smLoop,
	input  wire logic [1:0] strapMode,
	input  wire logic       dchanInhibitPin,
	output logic [2:0]      txSignalCode,
	output logic            contPulseTest,
	output logic            singlePulseTest,
	output logic            txDataForceOne,
	output logic            dchanPriority,
	output logic            powerDown,
	output logic            analogLoopClose,
	output logic            externalLoop,
	output logic            swLayer1,
	output logic            multiframeOn,
	output logic            txAuxBit,
	output logic            txAuxValid,
	output logic            echoInvert,
	output logic [2:0]      operatingSelect,
	output logic            transceiverIrq
);

	stl1_state_t state_ff;
	logic [7:0]  conf0_ff;
	logic [7:0]  sta_ff;
	logic [7:0]  cmd_ff;
	logic [7:0]  sqx1_ff;
	logic [7:0]  sqx2_ff;
	logic [7:0]  sqx3_ff;
	logic [3:0]  sqr1_ff;
	logic [7:0]  sqr2_ff;
	logic [7:0]  sqr3_ff;
	logic [19:0] rxShadow_ff;
	logic [2:0]  sqcPend_ff;
	logic        ric_ff;
	logic        sqw_ff;
	logic        ldIst_ff;
	logic [7:0]  mask_ff;
	logic [3:0]  mode_ff;
	logic        dchWritten_ff;
	logic [7:0]  rdData_ff;
	logic [2:0]  txCode_ff;
	logic        contPulse_ff;
	logic        singlePulse_ff;
	logic        forceOne_ff;
	logic        dchan_priority_class_ff;
	logic        pd_ff;
	logic        loop_ff;
	logic        exLoop_ff;
	logic        mfOn_ff;
	logic        auxBit_ff;
	logic        auxValid_ff;
	logic        echoInv_ff;
	logic        irq_ff;

	logic [2:0]  curSub;
	logic [1:0]  curBit;
	logic        curLast;
	logic [2:0]  nextSub;
	logic [1:0]  nextBit;

	stl1_mf_counter u_mf (
		.clk         (clk),
		.rst_n       (rst_n),
		.frameStrobe (frameStrobe),
		.mfStart     (mfStart),
		.curSub      (curSub),
		.curBit      (curBit),
		.curLast     (curLast),
		.nextSub     (nextSub),
		.nextBit     (nextBit)
	);

	// Address decode
	wire wrConf0 = regWrStb && (regAddr == ADDR_CONF0);
	wire wrCmd   = regWrStb && (regAddr == ADDR_CMD);
	wire wrSqx1  = regWrStb && (regAddr == ADDR_MAINT_CHANNEL_TRANSMIT_1);
	wire wrSqx2  = regWrStb && (regAddr == ADDR_MAINT_CHANNEL_TRANSMIT_2);
	wire wrSqx3  = regWrStb && (regAddr == ADDR_MAINT_CHANNEL_TRANSMIT_3);
	wire wrMode  = regWrStb && (regAddr == ADDR_MODE);
	wire wrMask  = regWrStb && (regAddr == ADDR_MASK);
	wire rdSta   = regRdStb && (regAddr == ADDR_STA);
	wire rdSqr1  = regRdStb && (regAddr == ADDR_MAINT_CHANNEL_RECEIVE_1);
	wire rdSqr2  = regRdStb && (regAddr == ADDR_MAINT_CHANNEL_RECEIVE_2);
	wire rdSqr3  = regRdStb && (regAddr == ADDR_MAINT_CHANNEL_RECEIVE_3);

	wire [2:0] opMode  = mode_ff[2:0];
	wire       software_layer1_select    = conf0_ff[CONF0_SOFTWARE_LAYER1_SELECT];
	wire       teSide  = isTeSide(opMode);
	wire       ntSide  = isNtSide(opMode);
	wire       multiframe_enable    = sqx1_ff[SQ_MULTIFRAME_ENABLE];

	// Received signal encoding; the second signal is reserved on the NT side
	wire [1:0] rinfNow = detInfoHigh ? RECEIVED_SIGNAL_FIELD_HIGH :
		(detInfo2 && teSide) ? RECEIVED_SIGNAL_FIELD_INFO2 :
		detInfo0 ? RECEIVED_SIGNAL_FIELD_IDLE : RECEIVED_SIGNAL_FIELD_OTHER;
	wire [7:0] staNow  = {rinfNow, 1'b0, rxSlip, rxCodeViol, rxFrameLock,
		1'b0, rxLevel};
	wire       ricSet  = (staNow[7:6] != sta_ff[7:6])
		|| (staNow[STA_ICV] != sta_ff[STA_ICV]);

	// Command view: host-owned with software layer 1, else internal machine
	wire [7:0] cmdSm   = {smXmitCode, smDprio, smTddis, smPowerDown, 1'b0, smLoop};
	wire [7:0] cmdView = software_layer1_select ? cmd_ff : cmdSm;
	wire       cmdAll  = wrCmd && software_layer1_select;
	wire       cmdPrio = wrCmd && !software_layer1_select && isIntNt(opMode);
	wire [7:0] nxt_cmd = cmdAll ? (regWrData & CMD_WMASK) :
		cmdPrio ? ((cmd_ff & ~DCHAN_PRIORITY_CLASS_MASK) | (regWrData & DCHAN_PRIORITY_CLASS_MASK)) : cmd_ff;

	// Maintenance channel receive: position within the 20-bit shadow
	wire [4:0] slot    = 5'(5'd19 - 5'(({2'b00, curSub} - 5'd1) * 5'd4)
		- {3'b000, curBit});
	wire       rxAllow = (curSub == SUB_FIRST) || teSide;
	wire       rxTake  = frameStrobe && multiframe_enable && rxMfLock && rxAllow;
	wire [19:0] nxt_shadow = rxTake ? (rxShadow_ff | (20'h00001 << slot)) &
		~(rxAuxBit ? 20'h00000 : (20'h00001 << slot)) : rxShadow_ff;
	wire       commit  = frameStrobe && curLast && multiframe_enable && rxMfLock;
	wire [2:0] sqChg   = {nxt_shadow[7:0] != sqr3_ff,
		nxt_shadow[15:8] != sqr2_ff,
		nxt_shadow[19:16] != sqr1_ff} & {teSide, teSide, 1'b1};

	// Transmit bit for the next frame slot
	function automatic logic pickTx(input logic [2:0] s, input logic [1:0] b,
		input logic [7:0] x1, input logic [7:0] x2, input logic [7:0] x3);
		logic [19:0] all;
		all = {x1[3:0], x2, x3};
		return all[5'(5'd19 - 5'(({2'b00, s} - 5'd1) * 5'd4) - {3'b000, b})];
	endfunction

	wire       txAllow = (nextSub == SUB_FIRST) || ntSide;
	wire [3:0] istat   = {ldIst_ff, ric_ff, |sqcPend_ff, sqw_ff};
	wire       dchRead = dchWritten_ff ? mode_ff[MODE_DCH] : dchanInhibitPin;

	// Read multiplexer; unmapped offsets read as zero
	wire [7:0] rdMux =
		(regAddr == ADDR_CONF0) ? conf0_ff :
		(regAddr == ADDR_STA)   ? sta_ff :
		(regAddr == ADDR_CMD)   ? cmdView :
		(regAddr == ADDR_MAINT_CHANNEL_RECEIVE_1) ? {rxMfLock, multiframe_enable, 2'b00, sqr1_ff} :
		(regAddr == ADDR_MAINT_CHANNEL_TRANSMIT_1) ? sqx1_ff :
		(regAddr == ADDR_MAINT_CHANNEL_RECEIVE_2) ? sqr2_ff :
		(regAddr == ADDR_MAINT_CHANNEL_TRANSMIT_2) ? sqx2_ff :
		(regAddr == ADDR_MAINT_CHANNEL_RECEIVE_3) ? sqr3_ff :
		(regAddr == ADDR_MAINT_CHANNEL_TRANSMIT_3) ? sqx3_ff :
		(regAddr == ADDR_ISTAT) ? {4'h0, istat} :
		(regAddr == ADDR_MODE)  ? {4'h0, dchRead, opMode} :
		(regAddr == ADDR_MASK)  ? mask_ff : 8'h00;

	// Straps are caught one edge after reset release, never by the reset itself
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff      <= ST_STRAP;
			mode_ff       <= MODE_RST;
			dchWritten_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				ST_STRAP: begin
					mode_ff  <= {2'b00, strapMode};
					state_ff <= ST_RUN;
				end
				ST_RUN: begin
					if (wrMode) begin
						mode_ff       <= regWrData[3:0];
						dchWritten_ff <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conf0_ff <= CONF0_RST;
			cmd_ff   <= CMD_RST;
			sqx1_ff  <= MAINT_CHANNEL_TRANSMIT_1_RST;
			sqx2_ff  <= SQXR_RST;
			sqx3_ff  <= SQXR_RST;
			mask_ff  <= MASK_RST;
		end else begin
			conf0_ff <= wrConf0 ? (regWrData & CONF0_WMASK) : conf0_ff;
			cmd_ff   <= nxt_cmd;
			sqx1_ff  <= wrSqx1 ? {1'b0, regWrData[6], 2'b00, regWrData[3:0]} : sqx1_ff;
			sqx2_ff  <= wrSqx2 ? regWrData : sqx2_ff;
			sqx3_ff  <= wrSqx3 ? regWrData : sqx3_ff;
			mask_ff  <= wrMask ? regWrData : mask_ff;
		end
	end

	// Status snapshot, receive registers and interrupt sources; set beats clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sta_ff      <= STA_RST;
			ric_ff      <= 1'b0;
			ldIst_ff    <= 1'b0;
			rxShadow_ff <= 20'h00000;
			sqr1_ff     <= SQRR_RST[3:0];
			sqr2_ff     <= SQRR_RST;
			sqr3_ff     <= SQRR_RST;
			sqcPend_ff  <= 3'b000;
			sqw_ff      <= 1'b0;
		end else begin
			sta_ff      <= staNow;
			ric_ff      <= ricSet || (ric_ff && !rdSta);
			ldIst_ff    <= rxLevel;
			rxShadow_ff <= nxt_shadow;
			if (commit) begin
				sqr1_ff <= nxt_shadow[19:16];
				if (teSide) begin
					sqr2_ff <= nxt_shadow[15:8];
					sqr3_ff <= nxt_shadow[7:0];
				end
			end
			sqcPend_ff <= (commit ? sqChg : 3'b000)
				| (sqcPend_ff & ~{rdSqr3, rdSqr2, rdSqr1});
			sqw_ff <= (commit && multiframe_enable) ||
				(sqw_ff && !(wrSqx1 || wrSqx2 || wrSqx3));
		end
	end

	// Registered outputs toward the line and the host
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_ff      <= 8'h00;
			txCode_ff      <= TRANSMIT_SIGNAL_FIELD_IDLE;
			contPulse_ff   <= 1'b0;
			singlePulse_ff <= 1'b0;
			forceOne_ff    <= 1'b0;
			dchan_priority_class_ff       <= 1'b0;
			pd_ff          <= 1'b0;
			loop_ff        <= 1'b0;
			exLoop_ff      <= 1'b0;
			mfOn_ff        <= 1'b0;
			auxBit_ff      <= 1'b1;
			auxValid_ff    <= 1'b0;
			echoInv_ff     <= 1'b0;
			irq_ff         <= 1'b0;
		end else begin
			rdData_ff      <= regRdStb ? rdMux : 8'h00;
			txCode_ff      <= cmdView[7:5];
			contPulse_ff   <= cmdView[7:5] == TRANSMIT_SIGNAL_FIELD_CONT;
			singlePulse_ff <= cmdView[7:5] == TRANSMIT_SIGNAL_FIELD_SINGLE;
			forceOne_ff    <= (opMode == OPM_TE) && cmdView[CMD_TRANSMIT_DATA_DISABLE]
				&& (cmdView[7:5] == TRANSMIT_SIGNAL_FIELD_HIGH);
			dchan_priority_class_ff       <= cmdView[CMD_DCHAN_PRIORITY_CLASS];
			pd_ff          <= cmdView[CMD_PD];
			loop_ff        <= cmdView[CMD_LPA];
			exLoop_ff      <= conf0_ff[CONF0_EXTERNAL_LOOP_SELECT];
			mfOn_ff        <= multiframe_enable;
			auxBit_ff      <= pickTx(nextSub, nextBit, sqx1_ff, sqx2_ff, sqx3_ff);
			auxValid_ff    <= multiframe_enable && txAllow;
			echoInv_ff     <= ntSide && (mode_ff[MODE_DCH] ^ dchanInhibitPin);
			irq_ff         <= |(istat & ~mask_ff[3:0]);
		end
	end

	assign regRdData       = rdData_ff;
	assign txSignalCode    = txCode_ff;
	assign contPulseTest   = contPulse_ff;
	assign singlePulseTest = singlePulse_ff;
	assign txDataForceOne  = forceOne_ff;
	assign dchanPriority   = dchan_priority_class_ff;
	assign powerDown       = pd_ff;
	assign analogLoopClose = loop_ff;
	assign externalLoop    = exLoop_ff;
	assign swLayer1        = software_layer1_select;
	assign multiframeOn    = mfOn_ff;
	assign txAuxBit        = auxBit_ff;
	assign txAuxValid      = auxValid_ff;
	assign echoInvert      = echoInv_ff;
	assign operatingSelect = opMode;
	assign transceiverIrq  = irq_ff;

	// Checks
	sequence s_lockedCmdWrite;
		wrCmd && !software_layer1_select && !isIntNt(opMode);
	endsequence

	property p_cmd_locked;
		@(posedge clk) disable iff (!rst_n)
		s_lockedCmdWrite |=> cmd_ff == $past(cmd_ff);
	endproperty
	a_cmd_locked: assert property (p_cmd_locked) else $error("command written while locked");

	property p_received_signal_field_code;
		@(posedge clk) disable iff (!rst_n)
		(detInfoHigh && state_ff == ST_RUN) |=> sta_ff[7:6] == RECEIVED_SIGNAL_FIELD_HIGH;
	endproperty
	a_received_signal_field_code: assert property (p_received_signal_field_code) else $error("received field not 11");

	property p_ld_irq;
		@(posedge clk) disable iff (!rst_n)
		rxLevel ##1 rxLevel |-> istat[IST_LD] && sta_ff[STA_LD];
	endproperty
	a_ld_irq: assert property (p_ld_irq) else $error("line activity bit dropped");

	sequence s_statusReadQuiet;
		rdSta && !ricSet;
	endsequence

	property p_ric_clear;
		@(posedge clk) disable iff (!rst_n)
		s_statusReadQuiet |=> !ric_ff;
	endproperty
	a_ric_clear: assert property (p_ric_clear) else $error("change flag not cleared");

	property p_ric_set;
		@(posedge clk) disable iff (!rst_n)
		ricSet |=> ric_ff [*1];
	endproperty
	a_ric_set: assert property (p_ric_set) else $error("change flag lost");

	property p_irq_mask;
		@(posedge clk) disable iff (!rst_n)
		##1 transceiverIrq == |($past(istat) & ~$past(mask_ff[3:0]));
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("interrupt mask mismatch");

	property p_force_one;
		@(posedge clk) disable iff (!rst_n)
		(opMode == OPM_TE && cmdView[CMD_TRANSMIT_DATA_DISABLE] && cmdView[7:5] == TRANSMIT_SIGNAL_FIELD_HIGH)
			##1 (opMode == OPM_TE && cmdView[CMD_TRANSMIT_DATA_DISABLE] && cmdView[7:5] == TRANSMIT_SIGNAL_FIELD_HIGH)
			|-> txDataForceOne;
	endproperty
	a_force_one: assert property (p_force_one) else $error("data not forced to ones");

	property p_test_pulse;
		@(posedge clk) disable iff (!rst_n)
		$changed(cmdView[7:5]) |=> contPulseTest == (txSignalCode == TRANSMIT_SIGNAL_FIELD_CONT)
			&& singlePulseTest == (txSignalCode == TRANSMIT_SIGNAL_FIELD_SINGLE);
	endproperty
	a_test_pulse: assert property (p_test_pulse) else $error("test pulse select wrong");

	property p_echo;
		@(posedge clk) disable iff (!rst_n)
		!ntSide |=> !echoInvert;
	endproperty
	a_echo: assert property (p_echo) else $error("echo inverted outside NT side");

	property p_sqw_clear;
		@(posedge clk) disable iff (!rst_n)
		(wrSqx1 || wrSqx2 || wrSqx3) && !commit |=> !sqw_ff;
	endproperty
	a_sqw_clear: assert property (p_sqw_clear) else $error("writable flag not cleared");

	property p_rd_once;
		@(posedge clk) disable iff (!rst_n)
		!regRdStb |=> regRdData == 8'h00;
	endproperty
	a_rd_once: assert property (p_rd_once) else $error("read data outside read cycle");

endmodule

// >>> bench/stl1_line_partner.sv
// Far-end line partner: frame strobes and S/Q bits from a fixed pattern.
// Assumes the bench raises run after reset and drops it between multiframes.
`timescale 1ns/10ps
module stl1_line_partner #(
	parameter int FRAME_CYC = 8
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic [19:0] pattern,
	output logic             frameStrobe,
	output logic             mfStart,
	output logic             rxAuxBit,
	output logic [3:0]       mfCount
);
	logic [3:0] cycCnt;
	logic [4:0] frameNo;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cycCnt      <= 4'h0;
			frameNo     <= 5'h0;
			frameStrobe <= 1'b0;
			mfStart     <= 1'b0;
			rxAuxBit    <= 1'b0;
			mfCount     <= 4'h0;
		end else begin
			frameStrobe <= 1'b0;
			mfStart     <= 1'b0;
			// Outside its slot the bit toggles, so a stale value never passes as data
			rxAuxBit    <= ~rxAuxBit;
			if (run) begin
				cycCnt <= (cycCnt == 4'(FRAME_CYC - 1)) ? 4'h0 : cycCnt + 4'h1;
				if (cycCnt == 4'h0) begin
					frameStrobe <= 1'b1;
					mfStart     <= (frameNo == 5'h0);
					rxAuxBit    <= pattern[frameNo];
					frameNo     <= (frameNo == 5'd19) ? 5'h0 : frameNo + 5'h1;
					if (frameNo == 5'd19)
						mfCount <= mfCount + 4'h1;
				end
			end
		end
	end
endmodule

// >>> bench/stl1_line_regs_tb.sv
// Bench of the layer-1 line register bank: host port tasks and a line partner.
// Assumes strap pins at 00 (TE mode) and a 20 MHz clock.
`timescale 1ns/10ps
module stl1_line_regs_tb
	import stl1_pkg::*;
;
	logic        clk, rst_n, regWrStb, regRdStb, run, dchanInhibitPin;
	logic        detInfo0, detInfo2, detInfoHigh, rxCodeViol, rxFrameLock, rxSlip;
	logic        rxLevel, rxMfLock, smDprio, smTddis, smPowerDown, smLoop;
	logic [2:0]  smXmitCode, txSignalCode, operatingSelect;
	logic [1:0]  strapMode;
	logic [7:0]  regAddr, regWrData, regRdData;
	logic [19:0] pattern;
	logic        contPulseTest, singlePulseTest, txDataForceOne, dchanPriority, powerDown;
	logic        analogLoopClose, externalLoop, swLayer1, multiframeOn, txAuxBit, txAuxValid;
	logic        echoInvert, transceiverIrq, frameStrobe, mfStart, rxAuxBit;
	logic [3:0]  mfCount;
	int          n_errors = 0;
	int          checks   = 0;
	wire  [8:0]  ctl = {txSignalCode, contPulseTest, singlePulseTest, txDataForceOne,
		dchanPriority, powerDown, analogLoopClose};
	logic [7:0]  rstVal [16] = '{8'h01, 8'h00, 8'h45, 8'h40, 8'h4f, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  cmdVal [5] = '{8'h00, 8'h59, 8'h6c, 8'h80, 8'ha0};

	stl1_line_regs dut (.*);
	stl1_line_partner partner (.*);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr   <= a;
		regWrData <= d;
		regWrStb  <= 1'b1;
		@(posedge clk);
		regWrStb  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr  <= a;
		regRdStb <= 1'b1;
		@(posedge clk);
		regRdStb <= 1'b0;
		#1 chk($sformatf("reg %h", a), regRdData, e);
	endtask

	// Command outputs follow one edge after the write edge
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask

	function automatic logic [3:0] nib(input int s);
		return {pattern[s-1], pattern[s+4], pattern[s+9], pattern[s+14]};
	endfunction

	task automatic finish_test;
		$display("Mismatches %0d, comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		int i;
		logic [7:0] c;
		{regAddr, regWrData, regWrStb, regRdStb, run, dchanInhibitPin} = '0;
		{detInfo0, detInfo2, detInfoHigh, rxCodeViol, rxFrameLock, rxSlip} = 6'b100000;
		{rxLevel, rxMfLock, strapMode} = '0;
		{smXmitCode, smDprio, smTddis, smPowerDown, smLoop} = 7'h23;
		pattern = 20'h6b3d9;
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 16; i++) rd(8'h30 + 8'(i), rstVal[i]);
		wr(ADDR_CMD, 8'hff);
		rd(ADDR_CMD, 8'h45);
		wr(ADDR_MODE, {5'h0, OPM_INT_NT});
		wr(ADDR_CMD, 8'hff);
		wr(ADDR_CONF0, 8'h0a);
		rd(ADDR_CMD, 8'h18);
		settle();
		chk("loop config", {externalLoop, swLayer1}, 2'b11);
		chk("aux slot", {txAuxValid, txAuxBit}, 9'h003);
		wr(ADDR_MODE, 8'h00);
		for (i = 0; i < 5; i++) begin
			c = cmdVal[i];
			wr(ADDR_CMD, c);
			rd(ADDR_CMD, c & CMD_WMASK);
			settle();
			chk("line controls", ctl, {c[7:5], c[7:5] == TRANSMIT_SIGNAL_FIELD_CONT, c[7:5] == TRANSMIT_SIGNAL_FIELD_SINGLE,
				c[3] && c[7:5] == TRANSMIT_SIGNAL_FIELD_HIGH, c[4], c[2], c[0]});
		end
		@(posedge clk);
		{detInfo0, detInfoHigh, rxCodeViol, rxFrameLock, rxSlip, rxLevel} <= 6'b011111;
		wr(ADDR_MASK, 8'h00);
		settle();
		chk("irq line", transceiverIrq, 1'b1);
		rd(ADDR_ISTAT, 8'h0c);
		rd(ADDR_STA, 8'hdd);
		rd(ADDR_ISTAT, 8'h08);
		wr(ADDR_MASK, 8'hff);
		settle();
		chk("irq line", transceiverIrq, 1'b0);
		wr(ADDR_MASK, 8'h00);
		@(posedge clk);
		rxMfLock <= 1'b1;
		run      <= 1'b1;
		for (i = 0; i < 2000 && mfCount != 4'h2; i++) @(posedge clk);
		run <= 1'b0;
		if (mfCount != 4'h2) begin
			n_errors++;
			finish_test();
		end
		repeat (4) @(posedge clk);
		rd(ADDR_ISTAT, 8'h0b);
		rd(ADDR_MAINT_CHANNEL_RECEIVE_1, {4'hc, nib(1)});
		rd(ADDR_MAINT_CHANNEL_RECEIVE_2, {nib(2), nib(3)});
		rd(ADDR_MAINT_CHANNEL_RECEIVE_3, {nib(4), nib(5)});
		rd(ADDR_ISTAT, 8'h09);
		wr(ADDR_MAINT_CHANNEL_TRANSMIT_2, 8'h5a);
		rd(ADDR_ISTAT, 8'h08);
		rd(ADDR_MAINT_CHANNEL_TRANSMIT_2, 8'h5a);
		wr(ADDR_MAINT_CHANNEL_TRANSMIT_1, 8'h0f);
		rd(ADDR_MAINT_CHANNEL_RECEIVE_1, {4'h8, nib(1)});
		chk("multiframe", multiframeOn, 1'b0);
		chk("aux valid", txAuxValid, 1'b0);
		wr(ADDR_MODE, {5'h0, OPM_NT});
		@(posedge clk);
		dchanInhibitPin <= 1'b1;
		settle();
		chk("echo invert", echoInvert, 1'b1);
		wr(ADDR_MODE, 8'h0a);
		settle();
		chk("echo invert", echoInvert, 1'b0);
		rd(ADDR_MODE, 8'h0a);
		chk("mode", operatingSelect, OPM_NT);
		finish_test();
	end
endmodule
